// ### hdl/uds_defines.vh
`ifndef UDS_DEFINES_VH
`define UDS_DEFINES_VH

// Command codes seen on the microcontroller command port
`define UDS_CMD_SEL_CLR_BASE 8'h40
`define UDS_CMD_EP_ENABLE 8'hD8
`define UDS_CMD_READ_INT 8'hF4
`define UDS_CMD_READ_FRAME 8'hF5
`define UDS_CMD_SET_STATUS 8'hFE
`define UDS_CMD_GET_STATUS 8'hFE
`define UDS_CMD_GET_ERROR 8'hFF

// Field positions
`define UDS_EN_BIT 0
`define UDS_INT_DEV_BIT 7
`define UDS_ST_SUSP_BIT 2
`define UDS_ST_SCHG_BIT 3
`define UDS_ST_BRST_BIT 4
`define UDS_ERR_OCC_BIT 4

// Reset values
`define UDS_INT_RST 8'h00
`define UDS_ERR_RST 4'h0

// Error codes
`define UDS_ERR_NONE 4'h0
`define UDS_ERR_PID_ENC 4'h1
`define UDS_ERR_PID_UNK 4'h2
`define UDS_ERR_UNEXP 4'h3
`define UDS_ERR_TOK_CRC 4'h4
`define UDS_ERR_DAT_CRC 4'h5
`define UDS_ERR_TIMEOUT 4'h6
`define UDS_ERR_BABBLE 4'h7
`define UDS_ERR_EOP 4'h8
`define UDS_ERR_NAK 4'h9
`define UDS_ERR_STALL 4'hA
`define UDS_ERR_OVERRUN 4'hB
`define UDS_ERR_RSVD 4'hC
`define UDS_ERR_STUFF 4'hD
`define UDS_ERR_SYNC 4'hE
`define UDS_ERR_TOGGLE 4'hF

// Timing
`define UDS_CLK_HZ 25000000
`define UDS_IDLE_US 3000
`define UDS_WAKE_CYCLES 250000

`endif

// ### hdl/uds_status.v
`timescale 1ns/1ps
// How it works
// - Bit 0 of the end-point enable write is the only enable flag and is 0 after power-on.
// - Interrupt bits 0..5 flag the six physical end-points, bit 6 reads zero, all clear at power-on.
// - Interrupt bit 7 flags a device event and is cleared by the get-status command.
// - Frame readout gives bits 7:0 first, then bits 10:8 with five zero bits above.
// - Status byte has suspend in bit 2, suspend change in 3, bus reset in 4, bits 1:0 zero.
// - Suspend sets after more than 3 ms of idle bus, clears on activity, no interrupt itself.
// - Writing 0 to suspend while suspended starts remote wake-up; other writes do nothing.
// - Suspend change sets and interrupts on each suspend toggle and clears on status read.
// - Bus reset flag sets and interrupts on a bus reset and clears on status read.
// - A bus reset puts the device back to unconfigured default state at address zero.
// - Error byte has code in bits 3:0 and occurred flag in bit 4, both zero at power-on.
// - Error codes 0000 to 1000 cover no error through end-of-packet error.
// - Error codes 1001 to 1111 cover NAK, STALL, overrun, reserved, stuff, sync, toggle.
// - The error occurred flag clears at the start of each new transfer.
// - Each end-point interrupt bit holds until its select-and-clear command.
// - Frame number is the 11 bits of the last SOF, kept even with a CRC error.
`include "uds_defines.vh"

module uds_status #(
  parameter IDLE_CYCLES = (`UDS_CLK_HZ / 1000000) * `UDS_IDLE_US,
  parameter WAKE_CYCLES = `UDS_WAKE_CYCLES
) (
  input wire clk_sys,
  input wire rst,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire wr_valid,
  input wire [7:0] wr_data,
  input wire rd_req,
  output reg [7:0] rd_data,
  output reg rd_valid,
  input wire bus_activity,
  input wire bus_reset,
  input wire sof_valid,
  input wire [10:0] sof_frame,
  input wire [5:0] ep_event,
  input wire xfer_start,
  input wire err_valid,
  input wire [3:0] err_code,
  output reg endpoints_enabled,
  output reg dev_configured,
  output reg addr_zero_only,
  output reg remote_wakeup,
  output reg int_n
);

  localparam S_IDLE = 6'h01;
  localparam S_INT = 6'h02;
  localparam S_FRM0 = 6'h04;
  localparam S_FRM1 = 6'h08;
  localparam S_STAT = 6'h10;
  localparam S_ERR = 6'h20;

  reg [5:0] state_q;
  reg [5:0] ep_int_q;
  reg dev_evt_q;
  reg [10:0] frame_q;
  reg susp_q;
  reg schg_q;
  reg brst_q;
  reg [3:0] err_code_q;
  reg err_occ_q;
  reg [31:0] idle_cnt_q;
  reg [31:0] wake_cnt_q;
  reg cmd_stat_q;
  reg [7:0] status_byte;
  reg susp_d;
  reg rd_stat;
  reg stat_wr;
  reg cmd_en_q;
  reg hit_rd_int;
  reg hit_rd_frame;
  reg hit_status;
  reg hit_rd_err;
  reg hit_ep_en;
  integer i;

  wire [7:0] int_byte = {dev_evt_q, 1'b0, ep_int_q};

  // One status code both reads and writes the status byte
  always @* begin
    hit_rd_int = cmd_valid && (cmd_code == `UDS_CMD_READ_INT);
    hit_rd_frame = cmd_valid && (cmd_code == `UDS_CMD_READ_FRAME);
    hit_status = cmd_valid && (cmd_code == `UDS_CMD_GET_STATUS);
    hit_rd_err = cmd_valid && (cmd_code == `UDS_CMD_GET_ERROR);
    hit_ep_en = cmd_valid && (cmd_code == `UDS_CMD_EP_ENABLE);
  end

  // True when the command selects end-point ep and clears its flag
  function sel_clr_hit;
    input [7:0] code;
    input [2:0] ep;
    begin
      sel_clr_hit = (code == (`UDS_CMD_SEL_CLR_BASE + {5'b00000, ep}));
    end
  endfunction

  // Reserved bits of the status byte read as zero
  always @* begin
    status_byte = 8'h00;
    status_byte[`UDS_ST_SUSP_BIT] = susp_q;
    status_byte[`UDS_ST_SCHG_BIT] = schg_q;
    status_byte[`UDS_ST_BRST_BIT] = brst_q;
  end

  // Suspend follows bus idle time; activity or reset wakes it
  always @* begin
    susp_d = susp_q;
    if (bus_activity || bus_reset) begin
      susp_d = 1'b0;
    end else if (idle_cnt_q > IDLE_CYCLES) begin
      susp_d = 1'b1;
    end
  end

  // Status read and status write strobes
  always @* begin
    rd_stat = rd_req && (state_q == S_STAT);
    stat_wr = wr_valid && cmd_stat_q;
  end

  // Idle count stops just past the limit so it cannot wrap
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= 32'h00000000;
      susp_q <= 1'b0;
    end else begin
      if (bus_activity || bus_reset) begin
        idle_cnt_q <= 32'h00000000;
      end else if (idle_cnt_q <= IDLE_CYCLES) begin
        idle_cnt_q <= idle_cnt_q + 32'h00000001;
      end
      susp_q <= susp_d;
    end
  end

  // Event flags: a new set wins over a clear in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      schg_q <= 1'b0;
      brst_q <= 1'b0;
      dev_evt_q <= 1'b0;
    end else begin
      if (susp_d != susp_q) begin
        schg_q <= 1'b1;
      end else if (rd_stat) begin
        schg_q <= 1'b0;
      end
      if (bus_reset) begin
        brst_q <= 1'b1;
      end else if (rd_stat) begin
        brst_q <= 1'b0;
      end
      if ((susp_d != susp_q) || bus_reset) begin
        dev_evt_q <= 1'b1;
      end else if (hit_status) begin
        dev_evt_q <= 1'b0;
      end
    end
  end

  // An end-point event wins over its clear command in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ep_int_q <= 6'h00;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        if (ep_event[i]) begin
          ep_int_q[i] <= 1'b1;
        end else if (cmd_valid && sel_clr_hit(cmd_code, i[2:0])) begin
          ep_int_q[i] <= 1'b0;
        end
      end
    end
  end

  // Keeps the last frame number whatever its CRC
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_q <= 11'h000;
    end else if (sof_valid) begin
      frame_q <= sof_frame;
    end
  end

  // A new error wins over the start of a transfer in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_code_q <= `UDS_ERR_RST;
      err_occ_q <= 1'b0;
    end else if (err_valid) begin
      err_code_q <= err_code;
      err_occ_q <= 1'b1;
    end else if (xfer_start) begin
      err_occ_q <= 1'b0;
    end
  end

  // Bus reset overrides an enable write landing in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      endpoints_enabled <= 1'b0;
      dev_configured <= 1'b0;
      addr_zero_only <= 1'b1;
    end else if (bus_reset) begin
      dev_configured <= 1'b0;
      addr_zero_only <= 1'b1;
      endpoints_enabled <= 1'b0;
    end else if (wr_valid && cmd_en_q) begin
      endpoints_enabled <= wr_data[`UDS_EN_BIT];
      dev_configured <= wr_data[`UDS_EN_BIT];
      addr_zero_only <= 1'b0;
    end
  end

  // Command decoder and read sequencer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      cmd_stat_q <= 1'b0;
      cmd_en_q <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (cmd_valid) begin
        cmd_stat_q <= (cmd_code == `UDS_CMD_SET_STATUS);
        cmd_en_q <= hit_ep_en;
        if (hit_rd_int) begin
          state_q <= S_INT;
        end else if (hit_rd_frame) begin
          state_q <= S_FRM0;
        end else if (hit_status) begin
          state_q <= S_STAT;
        end else if (hit_rd_err) begin
          state_q <= S_ERR;
        end else begin
          state_q <= S_IDLE;
        end
      end else if (rd_req) begin
        rd_valid <= 1'b1;
        case (state_q)
          S_INT: begin
            rd_data <= int_byte;
            state_q <= S_IDLE;
          end
          // Frame bytes come out low byte first
          S_FRM0: begin
            rd_data <= frame_q[7:0];
            state_q <= S_FRM1;
          end
          S_FRM1: begin
            rd_data <= {5'b00000, frame_q[10:8]};
            state_q <= S_IDLE;
          end
          S_STAT: begin
            rd_data <= status_byte;
            state_q <= S_IDLE;
          end
          S_ERR: begin
            rd_data <= {3'b000, err_occ_q, err_code_q};
            state_q <= S_IDLE;
          end
          default: begin
            // No read pending: answer with zero
            rd_data <= 8'h00;
          end
        endcase
      end
    end
  end

  // Remote wake-up pulse only when suspended and 0 is written
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_cnt_q <= 32'h00000000;
      remote_wakeup <= 1'b0;
    end else begin
      if (stat_wr && susp_q && !wr_data[`UDS_ST_SUSP_BIT]) begin
        wake_cnt_q <= WAKE_CYCLES;
        remote_wakeup <= 1'b1;
      end else if (wake_cnt_q != 32'h00000000) begin
        wake_cnt_q <= wake_cnt_q - 32'h00000001;
        remote_wakeup <= (wake_cnt_q != 32'h00000001);
      end else begin
        remote_wakeup <= 1'b0;
      end
    end
  end

  // Interrupt follows the flags one clock later
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(|int_byte);
    end
  end

endmodule

// ### dv/uds_status_chk.sv
`timescale 1ns/1ps
module uds_status_chk (
  input wire clk_sys,
  input wire rst,
  input wire wr_valid,
  input wire rd_req,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire bus_reset,
  input wire [5:0] ep_event,
  input wire endpoints_enabled,
  input wire dev_configured,
  input wire addr_zero_only,
  input wire remote_wakeup,
  input wire int_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_ans; rd_req |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no answer");
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data moved");
  property p_ep_int; |ep_event |-> ##[1:2] !int_n; endproperty
  a_ep_int: assert property (p_ep_int) else $error("no ep irq");
  property p_brst_int; bus_reset |-> ##[1:2] !int_n; endproperty
  a_brst_int: assert property (p_brst_int) else $error("no irq");
  property p_brst_def; bus_reset |=> addr_zero_only && !dev_configured;
  endproperty
  a_brst_def: assert property (p_brst_def) else $error("no dflt");
  property p_cfg; dev_configured |-> !addr_zero_only; endproperty
  a_cfg: assert property (p_cfg) else $error("addr state");
  property p_en; $rose(endpoints_enabled) |-> $past(wr_valid); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_wake;
    $rose(remote_wakeup) |-> $past(wr_valid) || $past(wr_valid, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  cover property (rd_req ##1 rd_valid);
  cover property ($rose(remote_wakeup));
  cover property (bus_reset ##1 addr_zero_only);
endmodule

bind uds_status uds_status_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .wr_valid(wr_valid), .rd_req(rd_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .bus_reset(bus_reset), .ep_event(ep_event),
  .endpoints_enabled(endpoints_enabled), .dev_configured(dev_configured),
  .addr_zero_only(addr_zero_only), .remote_wakeup(remote_wakeup),
  .int_n(int_n));

// ### dv/uds_link_model.sv
`timescale 1ns/1ps
module uds_link_model (
  input wire logic clk_sys,
  output logic bus_activity,
  output logic bus_reset,
  output logic sof_valid,
  output logic [10:0] sof_frame
);
  logic keep = 1'b1;
  logic [3:0] n = 4'h0;
  initial begin
    bus_activity = 0;
    bus_reset = 0;
    sof_valid = 0;
    sof_frame = 11'h555;
  end
  // Traffic every 16 cycles keeps the port out of suspend
  always @(posedge clk_sys) begin
    n <= n + 4'h1;
    bus_activity <= #1 keep && n == 4'h0;
  end
  task sof(input logic [10:0] f);
    sof_frame = f;
    sof_valid = 1;
    @(posedge clk_sys);
    #1 sof_valid = 0;
    sof_frame = ~f;
    @(posedge clk_sys);
    #1;
  endtask
  task breset();
    bus_reset = 1;
    @(posedge clk_sys);
    #1 bus_reset = 0;
  endtask
endmodule

// ### dv/test_uds_status.sv
`timescale 1ns/1ps
module test_uds_status;
  logic clk_sys = 0;
  logic rst = 1;
  logic cmd_valid = 0, wr_valid = 0, rd_req = 0, xfer_start = 0;
  logic err_valid = 0;
  logic [7:0] cmd_code = 0, wr_data = 0, d;
  logic [5:0] ep_event = 0;
  logic [3:0] err_code = 0;
  logic [31:0] f;
  logic [7:0] q[$];
  wire [7:0] rd_data;
  wire [10:0] sof_frame;
  wire rd_valid, bus_activity, bus_reset, sof_valid, endpoints_enabled;
  wire dev_configured, addr_zero_only, remote_wakeup, int_n;
  int miscompares = 0, comparisons = 0, n;
  always #20 clk_sys = ~clk_sys;
  uds_link_model u_link (.clk_sys(clk_sys), .bus_activity(bus_activity),
    .bus_reset(bus_reset), .sof_valid(sof_valid), .sof_frame(sof_frame));
  uds_status #(.IDLE_CYCLES(60), .WAKE_CYCLES(10)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .bus_activity(bus_activity), .bus_reset(bus_reset),
    .sof_valid(sof_valid), .sof_frame(sof_frame), .ep_event(ep_event),
    .xfer_start(xfer_start), .err_valid(err_valid), .err_code(err_code),
    .endpoints_enabled(endpoints_enabled), .dev_configured(dev_configured),
    .addr_zero_only(addr_zero_only), .remote_wakeup(remote_wakeup),
    .int_n(int_n));
  task final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmd(input logic [7:0] c);
    cmd_valid = 1;
    cmd_code = c;
    @(posedge clk_sys);
    #1 cmd_valid = 0;
  endtask
  task wr(input logic [7:0] v);
    wr_valid = 1;
    wr_data = v;
    @(posedge clk_sys);
    #1 wr_valid = 0;
  endtask
  task rd(output logic [7:0] v);
    int i;
    rd_req = 1;
    @(posedge clk_sys);
    #1 rd_req = 0;
    for (i = 0; i < 8 && rd_valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 8) begin
      miscompares++;
      final_report();
    end
    v = rd_data;
    @(posedge clk_sys);
    #1;
  endtask
  // Issues a read command and checks every queued expected byte
  task ex(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] v;
    q.push_back(e);
    cmd(c);
    while (q.size() > 0) begin
      rd(v);
      cmp(v, q.pop_front());
    end
  endtask
  initial begin
    f = $urandom(32'h1A47);
    repeat (4) @(posedge clk_sys);
    #1 rst = 0;
    ex(8'hF4, 8'h00);
    ex(8'hFE, 8'h00);
    ex(8'hFF, 8'h00);
    cmp({7'h00, endpoints_enabled}, 8'h00);
    for (n = 0; n < 2; n++) begin
      f = $urandom;
      u_link.sof(f[10:0]);
    end
    q.push_back(f[7:0]);
    ex(8'hF5, {5'h00, f[10:8]});
    for (n = 0; n < 6; n++) begin
      ep_event = 6'h01 << n;
      @(posedge clk_sys);
      #1 ep_event = 0;
      repeat (2) @(posedge clk_sys);
      #1 cmp({7'h00, int_n}, 8'h00);
      ex(8'hF4, 8'h01 << n);
      cmd(8'h40 + n[7:0]);
      rd(d);
      cmp(d, 8'h00);
      ex(8'hF4, 8'h00);
    end
    cmp({7'h00, int_n}, 8'h01);
    for (n = 0; n < 16; n++) begin
      err_valid = 1;
      err_code = n[3:0];
      @(posedge clk_sys);
      #1 err_valid = 0;
      ex(8'hFF, {4'h1, n[3:0]});
    end
    xfer_start = 1;
    @(posedge clk_sys);
    #1 xfer_start = 0;
    ex(8'hFF, 8'h0F);
    cmd(8'hD8);
    wr(8'h01);
    cmp({7'h00, endpoints_enabled}, 8'h01);
    u_link.breset();
    #40 cmp({6'h00, dev_configured, addr_zero_only}, 8'h01);
    ex(8'hF4, 8'h80);
    ex(8'hFE, 8'h10);
    ex(8'hF4, 8'h00);
    cmd(8'hFE);
    wr(8'h00);
    repeat (2) @(posedge clk_sys);
    #1 cmp({7'h00, remote_wakeup}, 8'h00);
    u_link.keep = 0;
    repeat (80) @(posedge clk_sys);
    #1 ex(8'hF4, 8'h80);
    ex(8'hFE, 8'h0C);
    cmd(8'hFE);
    wr(8'h04);
    #1 cmp({7'h00, remote_wakeup}, 8'h00);
    cmd(8'hFE);
    wr(8'h00);
    repeat (2) @(posedge clk_sys);
    #1 cmp({7'h00, remote_wakeup}, 8'h01);
    u_link.keep = 1;
    repeat (40) @(posedge clk_sys);
    #1 ex(8'hFE, 8'h08);
    final_report();
  end
endmodule
